// *** rtl/bcu_pkg.sv ***
// package of shared constants and types for the branch control unit
package bcu_pkg;
    // ************************************************************
    // widths and register numbers
    // ************************************************************
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_IDX_W = 4;
    localparam logic [3:0] LINK_REG_IDX = 4'he;
    localparam logic [3:0] PC_REG_IDX = 4'hf;
    localparam logic [3:0] LOW_REG_MAX = 4'h7;
    localparam int unsigned COND_W = 4;
    localparam logic [3:0] COND_ALWAYS = 4'he;
    localparam int unsigned BLOCK_MAX = 4;
    localparam int unsigned BLOCK_CNT_W = 3;

    // ************************************************************
    // branch ranges in bytes
    // ************************************************************
    localparam logic signed [32:0] RANGE_SHORT = 33'sh0_0010_0000;
    localparam logic signed [32:0] RANGE_LONG = 33'sh0_0100_0000;
    localparam logic [31:0] ZT_MIN_OFS = 32'h0000_0004;
    localparam logic [31:0] ZT_MAX_OFS = 32'h0000_0082;
    localparam logic [31:0] INSTR_STEP_NARROW = 32'h0000_0002;
    localparam logic [31:0] INSTR_STEP_WIDE = 32'h0000_0004;

    // ************************************************************
    // branch kinds
    // ************************************************************
    typedef enum logic [2:0] {
        BR_NONE = 3'b000,
        BR_PLAIN = 3'b001,
        BR_CALL_IMMEDIATE = 3'b010,
        BR_JUMP_REGISTER = 3'b011,
        BR_CALL_REGISTER = 3'b100,
        BR_IF_ZERO = 3'b101,
        BR_IF_NONZERO = 3'b110,
        BR_BLOCK_PREFIX = 3'b111
    } bcu_kind_t;

    // decoded request from the instruction stream
    typedef struct packed {
        bcu_kind_t kind;
        logic [COND_W-1:0] cond;
        logic [3:0] block_mask;
        logic wide;
        logic [REG_IDX_W-1:0] src_reg;
        logic [31:0] offset;
        logic [31:0] pc;
    } bcu_req_t;

    // result toward register file and program counter
    typedef struct packed {
        logic redirect;
        logic [31:0] target;
        logic link_we;
        logic [31:0] link_data;
        logic fault;
        logic range_err;
    } bcu_res_t;
endpackage

// *** rtl/bcu_cond_eval.sv ***
// condition code evaluation against the current flags
`timescale 1ns/1ps
`default_nettype none
module bcu_cond_eval (
    // condition and flags
    input wire logic [3:0] cond_in,
    input wire logic [3:0] flags_in,
    // verdict
    output logic pass_out
);
    logic n;
    logic z;
    logic c;
    logic v;
    logic base;
    assign {n, z, c, v} = flags_in;
    always_comb begin
        unique case (cond_in[3:1])
            3'h0: base = z;
            3'h1: base = c;
            3'h2: base = n;
            3'h3: base = v;
            3'h4: base = c & ~z;
            3'h5: base = (n == v);
            3'h6: base = ~z & (n == v);
            3'h7: base = 1'b1;
        endcase
    end
    // odd codes invert, except the always pair
    assign pass_out = (cond_in[0] && cond_in[3:1] != 3'h7) ? ~base : base;
endmodule // bcu_cond_eval
`default_nettype wire

// *** rtl/bcu_branch_unit.sv ***
// branch execution unit: targets, link writes, range checks, faults
// Summary of operation
// - every branch redirects to a pc-relative label or the source register address
// - call forms write the following instruction address into the link register
// - register branch target is the source value with bit 0 forced to zero
// - register branches with bit 0 clear raise the illegal state fault instead
// - conditional branch outside a block reaches one megabyte either way
// - conditional branch inside a block and immediate calls reach sixteen megabytes
// - register branches accept any target value without range limit
// - plain, call and register branches leave the flags untouched
// - zero test branches when equal to zero, nonzero variant when not equal
// - zero test compares internally without updating any flag
// - zero test accepts only tested registers zero to seven
// - zero test reaches only four to one hundred thirty bytes forward
// - block prefix makes up to four following instructions conditional
`timescale 1ns/1ps
`default_nettype none
module bcu_branch_unit (
    // clock and reset
    input wire logic CORE_CLK_IN,
    input wire logic RST_IN,
    // decoded instruction stream
    input wire logic REQ_VALID_IN,
    input wire bcu_pkg::bcu_req_t REQ_IN,
    // register file read data and flags
    input wire logic [31:0] SRC_DATA_IN,
    input wire logic [3:0] FLAGS_IN,
    // register file, pc and fault results
    output bcu_pkg::bcu_res_t RES_OUT,
    output logic [3:0] FLAGS_OUT,
    output logic FLUSH_OUT,
    output logic IN_BLOCK_OUT,
    output logic MISPLACED_OUT
);
    import bcu_pkg::*;

    // ************************************************************
    // block state
    // ************************************************************
    logic [BLOCK_CNT_W-1:0] blk_left_r;
    logic [BLOCK_CNT_W-1:0] blk_left_nxt;
    logic [COND_W-1:0] blk_cond_r;
    logic [3:0] blk_mask_r;
    logic [3:0] blk_mask_nxt;
    logic [COND_W-1:0] slot_cond;
    logic in_block;
    logic last_slot;
    logic cond_pass;
    logic [COND_W-1:0] eff_cond;
    logic res_taken;

    assign in_block = (blk_left_r != '0);
    assign last_slot = (blk_left_r == BLOCK_CNT_W'(1));
    // slot condition is base or its inverse
    assign slot_cond = {blk_cond_r[3:1], blk_cond_r[0] ^ blk_mask_r[3]};
    assign eff_cond = in_block ? slot_cond : REQ_IN.cond;

    bcu_cond_eval u_cond (
        .cond_in(eff_cond),
        .flags_in(FLAGS_IN),
        .pass_out(cond_pass)
    );

    always_comb begin
        blk_left_nxt = blk_left_r;
        blk_mask_nxt = blk_mask_r;
        if (REQ_VALID_IN) begin
            if (REQ_IN.kind == BR_BLOCK_PREFIX && !in_block) begin
                blk_left_nxt = BLOCK_CNT_W'(BLOCK_MAX);
                // first slot runs on the base condition, mask bits serve later slots
                blk_mask_nxt = {1'b0, REQ_IN.block_mask[3:1]};
                if (REQ_IN.block_mask[2:0] == 3'h0) begin
                    blk_left_nxt = BLOCK_CNT_W'(1);
                end else if (REQ_IN.block_mask[1:0] == 2'h0) begin
                    blk_left_nxt = BLOCK_CNT_W'(2);
                end else if (REQ_IN.block_mask[0] == 1'b0) begin
                    blk_left_nxt = BLOCK_CNT_W'(3);
                end
            end else if (in_block) begin
                blk_left_nxt = blk_left_r - BLOCK_CNT_W'(1);
                blk_mask_nxt = {blk_mask_r[2:0], 1'b0};
            end
            if (res_taken) begin
                blk_left_nxt = '0;
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            blk_left_r <= '0;
            blk_mask_r <= 4'h0;
            blk_cond_r <= COND_ALWAYS;
        end else begin
            blk_left_r <= blk_left_nxt;
            blk_mask_r <= blk_mask_nxt;
            if (REQ_VALID_IN && REQ_IN.kind == BR_BLOCK_PREFIX && !in_block) begin
                blk_cond_r <= REQ_IN.cond;
            end
        end
    end

    // ************************************************************
    // target and checks
    // ************************************************************
    logic is_imm;
    logic is_reg;
    logic is_zt;
    logic is_call;
    logic zt_hit;
    logic [31:0] imm_target;
    logic [31:0] reg_target;
    logic signed [32:0] ofs_s;
    logic range_bad;
    logic zt_bad;
    logic placement_bad;
    logic fault_now;
    logic [31:0] next_pc;

    assign is_imm = (REQ_IN.kind == BR_PLAIN) || (REQ_IN.kind == BR_CALL_IMMEDIATE);
    assign is_reg = (REQ_IN.kind == BR_JUMP_REGISTER) || (REQ_IN.kind == BR_CALL_REGISTER);
    assign is_zt = (REQ_IN.kind == BR_IF_ZERO) || (REQ_IN.kind == BR_IF_NONZERO);
    assign is_call = (REQ_IN.kind == BR_CALL_IMMEDIATE) || (REQ_IN.kind == BR_CALL_REGISTER);
    assign ofs_s = {REQ_IN.offset[31], REQ_IN.offset};
    assign next_pc = REQ_IN.pc + (REQ_IN.wide ? INSTR_STEP_WIDE : INSTR_STEP_NARROW);

    assign imm_target = REQ_IN.pc + {REQ_IN.offset[31:1], 1'b0};
    // clear bit 0 of source value
    assign reg_target = {SRC_DATA_IN[31:1], 1'b0};

    assign zt_hit = (REQ_IN.kind == BR_IF_ZERO) ? (SRC_DATA_IN == 32'h0000_0000)
                                                : (SRC_DATA_IN != 32'h0000_0000);

    always_comb begin
        range_bad = 1'b0;
        if (is_imm) begin
            if (REQ_IN.kind == BR_PLAIN && !in_block && REQ_IN.cond != COND_ALWAYS) begin
                range_bad = (ofs_s < -RANGE_SHORT) || (ofs_s > RANGE_SHORT);
            end else begin
                range_bad = (ofs_s < -RANGE_LONG) || (ofs_s > RANGE_LONG);
            end
        end
    end

    assign zt_bad = is_zt && ((REQ_IN.src_reg > LOW_REG_MAX) || (REQ_IN.offset < ZT_MIN_OFS)
                              || (REQ_IN.offset > ZT_MAX_OFS));

    // placement checks reported, call source never pc
    assign placement_bad = REQ_VALID_IN && ((in_block && (is_imm || is_reg) && !last_slot)
                           || (in_block && is_zt)
                           || (REQ_IN.kind == BR_CALL_REGISTER && REQ_IN.src_reg == PC_REG_IDX));

    assign fault_now = REQ_VALID_IN && is_reg && cond_pass && !SRC_DATA_IN[0];
    // register targets carry no range check
    assign res_taken = REQ_VALID_IN && !fault_now && !range_bad && !zt_bad
                       && ((is_imm && cond_pass) || (is_reg && cond_pass) || (is_zt && zt_hit));

    // ************************************************************
    // result registers
    // ************************************************************
    // redirect, link write
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            RES_OUT <= '0;
        end else begin
            RES_OUT.redirect <= res_taken;
            RES_OUT.target <= is_reg ? reg_target : imm_target;
            RES_OUT.link_we <= res_taken && is_call;
            RES_OUT.link_data <= next_pc;
            RES_OUT.fault <= fault_now;
            RES_OUT.range_err <= REQ_VALID_IN && (range_bad || zt_bad);
        end
    end

    // discard fetched work after a taken branch
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            FLUSH_OUT <= 1'b0;
            MISPLACED_OUT <= 1'b0;
        end else begin
            FLUSH_OUT <= res_taken || fault_now;
            MISPLACED_OUT <= placement_bad;
        end
    end

    assign FLAGS_OUT = FLAGS_IN;
    assign IN_BLOCK_OUT = in_block;

    // ************************************************************
    // assertions
    // ************************************************************
    property p_link_pc;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (REQ_VALID_IN && res_taken && is_call) |=> (RES_OUT.link_we
            && RES_OUT.link_data == $past(next_pc));
    endproperty
    a_link_pc: assert property (p_link_pc) else $error("link write missing");

    property p_bit0_clear;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        RES_OUT.redirect |-> (RES_OUT.target[0] == 1'b0);
    endproperty
    a_bit0_clear: assert property (p_bit0_clear) else $error("odd target");

    property p_fault;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (REQ_VALID_IN && is_reg && cond_pass && !SRC_DATA_IN[0])
            |=> (RES_OUT.fault && !RES_OUT.redirect);
    endproperty
    a_fault: assert property (p_fault) else $error("fault not raised");

    property p_short_range;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (REQ_VALID_IN && REQ_IN.kind == BR_PLAIN && !in_block && REQ_IN.cond != COND_ALWAYS
            && ofs_s > RANGE_SHORT) |=> !RES_OUT.redirect;
    endproperty
    a_short_range: assert property (p_short_range) else $error("short range");

    property p_long_range;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (REQ_VALID_IN && REQ_IN.kind == BR_CALL_IMMEDIATE && ofs_s <= RANGE_LONG
            && ofs_s >= -RANGE_LONG && cond_pass) |=> RES_OUT.redirect;
    endproperty
    a_long_range: assert property (p_long_range) else $error("call refused");

    property p_flags;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        REQ_VALID_IN |-> (FLAGS_OUT == FLAGS_IN);
    endproperty
    a_flags: assert property (p_flags) else $error("flags changed");

    property p_zero_test;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (REQ_VALID_IN && REQ_IN.kind == BR_IF_ZERO && !zt_bad && SRC_DATA_IN == 32'h0)
            |=> (RES_OUT.redirect && RES_OUT.target == $past(imm_target));
    endproperty
    a_zero_test: assert property (p_zero_test) else $error("zero test");

    property p_zt_window;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (REQ_VALID_IN && is_zt && REQ_IN.offset > ZT_MAX_OFS) |=> !RES_OUT.redirect;
    endproperty
    a_zt_window: assert property (p_zt_window) else $error("zero test range");

    property p_block_len;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        blk_left_r <= BLOCK_CNT_W'(BLOCK_MAX);
    endproperty
    a_block_len: assert property (p_block_len) else $error("block too long");

    property p_flush;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        RES_OUT.redirect |-> FLUSH_OUT;
    endproperty
    a_flush: assert property (p_flush) else $error("no flush");

    property p_reg_any;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (REQ_VALID_IN && is_reg && cond_pass && SRC_DATA_IN[0])
            |=> (RES_OUT.redirect && !RES_OUT.range_err
            && RES_OUT.target == {$past(SRC_DATA_IN[31:1]), 1'b0});
    endproperty
    a_reg_any: assert property (p_reg_any) else $error("register target refused");

    property p_zt_low;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (REQ_VALID_IN && is_zt && REQ_IN.src_reg > LOW_REG_MAX)
            |=> (RES_OUT.range_err && !RES_OUT.redirect);
    endproperty
    a_zt_low: assert property (p_zt_low) else $error("high tested register");

    property p_nonzero;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (REQ_VALID_IN && REQ_IN.kind == BR_IF_NONZERO && !zt_bad
            && SRC_DATA_IN != 32'h0000_0000) |=> RES_OUT.redirect;
    endproperty
    a_nonzero: assert property (p_nonzero) else $error("nonzero test");

    property p_not_last;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (REQ_VALID_IN && in_block && !last_slot && (is_imm || is_reg)) |=> MISPLACED_OUT;
    endproperty
    a_not_last: assert property (p_not_last) else $error("early branch in block");

    property p_block_end;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (REQ_VALID_IN && last_slot) |=> !in_block;
    endproperty
    a_block_end: assert property (p_block_end) else $error("block not closed");

    property p_no_link;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (REQ_VALID_IN && !is_call) |=> !RES_OUT.link_we;
    endproperty
    a_no_link: assert property (p_no_link) else $error("stray link write");

    c_call: cover property (@(posedge CORE_CLK_IN) RES_OUT.link_we);
    c_fault: cover property (@(posedge CORE_CLK_IN) RES_OUT.fault);
    c_block: cover property (@(posedge CORE_CLK_IN) in_block && res_taken);
    c_zt: cover property (@(posedge CORE_CLK_IN) REQ_VALID_IN && is_zt && res_taken);
    c_range: cover property (@(posedge CORE_CLK_IN) RES_OUT.range_err);
endmodule // bcu_branch_unit
`default_nettype wire

// *** testbench/bcu_stream_model.sv ***
// partner model: decoded instruction stream with register data and flags
`timescale 1ns/1ps
`default_nettype none
module bcu_stream_model
    import bcu_pkg::*;
(
    // clock
    input wire logic clk_in,
    // decoded stream toward the unit
    output logic valid_out,
    output bcu_pkg::bcu_req_t req_out,
    output logic [31:0] src_data_out,
    output logic [3:0] flags_out
);
    initial begin
        valid_out = 1'b0;
        req_out = '0;
        src_data_out = 32'h0;
        flags_out = 4'h0;
    end

    // ****************
    // issue one instruction
    // ****************
    // placement legal unless a scenario asks otherwise
    task automatic issue(input bcu_kind_t k, input logic [3:0] c, input logic [3:0] m,
            input logic w, input logic [3:0] s, input logic [31:0] o, input logic [31:0] p,
            input logic [31:0] d, input logic [3:0] f);
        @(posedge clk_in);
        valid_out <= 1'b1;
        req_out <= '{kind: k, cond: c, block_mask: m, wide: w, src_reg: s, offset: o, pc: p};
        src_data_out <= d;
        flags_out <= f;
        @(posedge clk_in);
        // released request and source data change rather than hold the last value, flags hold
        valid_out <= 1'b0;
        req_out <= bcu_req_t'(~req_out);
        src_data_out <= ~d;
    endtask
endmodule // bcu_stream_model
`default_nettype wire

// *** testbench/branch_control_unit_bench.sv ***
// self-checking bench for the branch control unit
`timescale 1ns/1ps
`default_nettype none
module branch_control_unit_bench;
    import bcu_pkg::*;
    localparam logic [31:0] P0 = 32'h0000_1000;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid;
    bcu_req_t req;
    logic [31:0] src_data;
    logic [3:0] flags;
    bcu_res_t res;
    logic [3:0] flags_seen;
    logic flush;
    logic in_block;
    logic misplaced;
    int n_fail = 0;
    int tests_run = 0;

    always #12.5 core_clk = ~core_clk;

    bcu_stream_model u_src (
        .clk_in(core_clk),
        .valid_out(req_valid),
        .req_out(req),
        .src_data_out(src_data),
        .flags_out(flags)
    );

    bcu_branch_unit u_dut (
        .CORE_CLK_IN(core_clk),
        .RST_IN(rst),
        .REQ_VALID_IN(req_valid),
        .REQ_IN(req),
        .SRC_DATA_IN(src_data),
        .FLAGS_IN(flags),
        .RES_OUT(res),
        .FLAGS_OUT(flags_seen),
        .FLUSH_OUT(flush),
        .IN_BLOCK_OUT(in_block),
        .MISPLACED_OUT(misplaced)
    );

    // ****************
    // shared tasks
    // ****************
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic go(input bcu_kind_t k, input logic [3:0] c, input logic [3:0] m,
            input logic w, input logic [3:0] s, input logic [31:0] o, input logic [31:0] d,
            input logic [3:0] f);
        u_src.issue(k, c, m, w, s, o, P0, d, f);
    endtask

    // b holds link write, fault, range error, misplaced
    task automatic chk_res(input logic rd, input logic [31:0] tg, input logic [31:0] ld,
            input logic [3:0] b);
        #1;
        chk("redirect", 32'(res.redirect), 32'(rd));
        if (rd) chk("target", res.target, tg);
        chk("link_we", 32'(res.link_we), 32'(b[3]));
        if (b[3]) chk("link_data", res.link_data, ld);
        chk("fault", 32'(res.fault), 32'(b[2]));
        chk("range_err", 32'(res.range_err), 32'(b[1]));
        chk("misplaced", 32'(misplaced), 32'(b[0]));
        chk("flush", 32'(flush), 32'(rd | b[2]));
        chk("flags", 32'(flags_seen), 32'(flags));
    endtask

    // ****************
    // scenarios
    // ****************
    task automatic t_immediate();
        go(BR_CALL_IMMEDIATE, COND_ALWAYS, 4'h0, 1'b1, 4'h0, 32'hff00_0000, 32'h0, 4'h0);
        chk_res(1'b1, P0 - 32'h0100_0000, P0 + 32'h4, 4'b1000);
        go(BR_PLAIN, COND_ALWAYS, 4'h0, 1'b1, 4'h0, 32'h0100_0000, 32'h0, 4'h3);
        chk_res(1'b1, P0 + 32'h0100_0000, 32'h0, 4'b0000);
        go(BR_PLAIN, COND_ALWAYS, 4'h0, 1'b1, 4'h0, 32'h0100_0002, 32'h0, 4'h3);
        chk_res(1'b0, 32'h0, 32'h0, 4'b0010);
        go(BR_PLAIN, 4'h0, 4'h0, 1'b1, 4'h0, 32'h0010_0000, 32'h0, 4'h4);
        chk_res(1'b1, P0 + 32'h0010_0000, 32'h0, 4'b0000);
        go(BR_PLAIN, 4'h0, 4'h0, 1'b1, 4'h0, 32'hffef_fffe, 32'h0, 4'h4);
        chk_res(1'b0, 32'h0, 32'h0, 4'b0010);
        go(BR_PLAIN, 4'h1, 4'h0, 1'b0, 4'h0, 32'h0000_0040, 32'h0, 4'h4);
        chk_res(1'b0, 32'h0, 32'h0, 4'b0000);
        // signed greater-or-equal with n and v both set passes
        go(BR_PLAIN, 4'ha, 4'h0, 1'b0, 4'h0, 32'h0000_0100, 32'h0, 4'h9);
        chk_res(1'b1, P0 + 32'h0000_0100, 32'h0, 4'b0000);
        // unsigned higher fails while z is set
        go(BR_PLAIN, 4'h8, 4'h0, 1'b0, 4'h0, 32'h0000_0100, 32'h0, 4'h6);
        chk_res(1'b0, 32'h0, 32'h0, 4'b0000);
    endtask

    task automatic t_register();
        go(BR_JUMP_REGISTER, COND_ALWAYS, 4'h0, 1'b0, 4'h3, 32'h0, 32'hffff_ffff, 4'h9);
        chk_res(1'b1, 32'hffff_fffe, 32'h0, 4'b0000);
        go(BR_CALL_REGISTER, COND_ALWAYS, 4'h0, 1'b0, 4'h2, 32'h0, 32'h8000_0001, 4'h9);
        chk_res(1'b1, 32'h8000_0000, P0 + 32'h2, 4'b1000);
        go(BR_CALL_REGISTER, COND_ALWAYS, 4'h0, 1'b0, 4'h2, 32'h0, 32'h0000_2000, 4'h9);
        chk_res(1'b0, 32'h0, 32'h0, 4'b0100);
    endtask

    task automatic t_zero();
        go(BR_IF_ZERO, COND_ALWAYS, 4'h0, 1'b0, 4'h7, 32'h4, 32'h0, 4'hf);
        chk_res(1'b1, P0 + 32'h4, 32'h0, 4'b0000);
        go(BR_IF_ZERO, COND_ALWAYS, 4'h0, 1'b0, 4'h7, 32'h4, 32'h1, 4'hf);
        chk_res(1'b0, 32'h0, 32'h0, 4'b0000);
        go(BR_IF_NONZERO, COND_ALWAYS, 4'h0, 1'b0, 4'h0, 32'h82, 32'h1, 4'hf);
        chk_res(1'b1, P0 + 32'h82, 32'h0, 4'b0000);
        go(BR_IF_NONZERO, COND_ALWAYS, 4'h0, 1'b0, 4'h0, 32'h84, 32'h1, 4'hf);
        chk_res(1'b0, 32'h0, 32'h0, 4'b0010);
        go(BR_IF_NONZERO, COND_ALWAYS, 4'h0, 1'b0, 4'h0, 32'h2, 32'h1, 4'hf);
        chk_res(1'b0, 32'h0, 32'h0, 4'b0010);
        go(BR_IF_ZERO, COND_ALWAYS, 4'h0, 1'b0, 4'h8, 32'h4, 32'h0, 4'hf);
        chk_res(1'b0, 32'h0, 32'h0, 4'b0010);
    endtask

    task automatic t_block();
        go(BR_BLOCK_PREFIX, 4'h0, 4'b1000, 1'b0, 4'h0, 32'h0, 32'h0, 4'h4);
        chk_res(1'b0, 32'h0, 32'h0, 4'b0000);
        chk("in_block", 32'(in_block), 32'h1);
        go(BR_PLAIN, 4'h0, 4'h0, 1'b1, 4'h0, 32'h0020_0000, 32'h0, 4'h4);
        chk_res(1'b1, P0 + 32'h0020_0000, 32'h0, 4'b0000);
        chk("in_block", 32'(in_block), 32'h0);
        go(BR_BLOCK_PREFIX, 4'h0, 4'b0100, 1'b0, 4'h0, 32'h0, 32'h0, 4'h4);
        go(BR_IF_ZERO, 4'h0, 4'h0, 1'b0, 4'h1, 32'h4, 32'h5, 4'h4);
        chk_res(1'b0, 32'h0, 32'h0, 4'b0001);
        go(BR_JUMP_REGISTER, 4'h0, 4'h0, 1'b0, 4'h1, 32'h0, 32'h0000_3001, 4'h4);
        chk_res(1'b1, 32'h0000_3000, 32'h0, 4'b0000);
        go(BR_BLOCK_PREFIX, 4'h0, 4'b0100, 1'b0, 4'h0, 32'h0, 32'h0, 4'h4);
        go(BR_PLAIN, 4'h0, 4'h0, 1'b0, 4'h0, 32'h10, 32'h0, 4'h4);
        chk_res(1'b1, P0 + 32'h10, 32'h0, 4'b0001);
        chk("in_block", 32'(in_block), 32'h0);
        go(BR_CALL_REGISTER, COND_ALWAYS, 4'h0, 1'b0, PC_REG_IDX, 32'h0, 32'h0000_4001, 4'h4);
        chk_res(1'b1, 32'h0000_4000, P0 + 32'h2, 4'b1001);
        // second slot runs on the inverse condition
        go(BR_BLOCK_PREFIX, 4'h0, 4'b1100, 1'b0, 4'h0, 32'h0, 32'h0, 4'h0);
        go(BR_NONE, 4'h0, 4'h0, 1'b0, 4'h0, 32'h0, 32'h0, 4'h0);
        chk_res(1'b0, 32'h0, 32'h0, 4'b0000);
        go(BR_PLAIN, 4'h1, 4'h0, 1'b0, 4'h0, 32'h20, 32'h0, 4'h0);
        chk_res(1'b1, P0 + 32'h20, 32'h0, 4'b0000);
        chk("in_block", 32'(in_block), 32'h0);
    endtask

    // reset in mid block clears the block and the results
    task automatic t_reset();
        go(BR_BLOCK_PREFIX, 4'h0, 4'b0001, 1'b0, 4'h0, 32'h0, 32'h0, 4'h0);
        chk_res(1'b0, 32'h0, 32'h0, 4'b0000);
        chk("in_block", 32'(in_block), 32'h1);
        @(posedge core_clk);
        rst <= 1'b1;
        @(posedge core_clk);
        #1;
        chk("reset", 32'({in_block, res.redirect, flush, misplaced}), 32'h0);
        @(posedge core_clk);
        rst <= 1'b0;
        go(BR_PLAIN, COND_ALWAYS, 4'h0, 1'b0, 4'h0, 32'h8, 32'h0, 4'h0);
        chk_res(1'b1, P0 + 32'h8, 32'h0, 4'b0000);
    endtask

    // ****************
    // verdict
    // ****************
    task automatic wrap_up();
        $display("checks %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #100us;
        n_fail++;
        wrap_up();
    end

    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        chk("idle", 32'({res.redirect, res.fault, res.link_we, flush, misplaced}), 32'h0);
        t_immediate();
        t_register();
        t_zero();
        t_block();
        t_reset();
        wrap_up();
    end
endmodule // branch_control_unit_bench
`default_nettype wire
